// [hdl/card_pins_cfg.svh]
// Constants for the card handshake and status pin block.
// Assumes a single 40 MHz core clock; included by bare name.
`ifndef CARD_PINS_CFG_SVH
`define CARD_PINS_CFG_SVH

// Data path widths
`define CFG_WORD_W 16
`define CFG_ADDR_W 11

// Burst buffer depth and the free-slot count below which write-ready drops
`define CFG_FIFO_DEPTH 8
`define CFG_RDY_MARGIN 2

// Core clock period and least half period of the read data strobe
`define CFG_CLK_NS 25
`define CFG_HALF_NS 50
`define CFG_HALF_CYC ((`CFG_HALF_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS)

// Reset and idle levels of the pins
`define CFG_PIN_RST 1'b1
`define CFG_STAT_RST 1'b1
`define CFG_STAT_PRE_INIT 1'b1
`define CFG_STROBE_RST 1'b0
`define CFG_WE_IDLE 1'b1

`endif

// [hdl/card_pins_pkg.sv]
// Types shared by the card handshake and status pin block.
// Assumes nothing of its surroundings; holds types only.
package card_pins_pkg;

   // Interface mode the card has been configured for
   typedef enum logic [1:0] {
      MODE_MEM,
      MODE_IO,
      MODE_IDE
   } mode_type;

   // Function carried by the shared wait pin
   typedef enum logic [1:0] {
      FN_WAIT,
      FN_IORDY,
      FN_DDMARDY,
      FN_DSTROBE
   } pin_fn_type;

endpackage

// [hdl/burst_fifo.sv]
// Synchronous FIFO holding burst words between host and core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module burst_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } fifo_state_type;

   fifo_state_type s_r;
   fifo_state_type s_nxt;
   logic push;
   logic pop;

   // Honest flags straight from the count
   assign in_ready = (s_r.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data = s_r.mem[s_r.rd];
   assign level = s_r.cnt;

   // Pointer and count update; simultaneous push and pop keeps the count
   always_comb begin
      s_nxt = s_r;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop) begin
         s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   // Storage is not cleared on reset, only the pointers and the count
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r.rd <= '0;
         s_r.wr <= '0;
         s_r.cnt <= '0;
         s_r.mem <= s_nxt.mem;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

`default_nettype wire

// [hdl/card_bus_handshake_status_pins.sv]
// Handshake and status pins of a removable flash card on its host bus.
// Assumes all pin inputs are already synchronous to mclk; the core
// supplies mode, burst flags and busy information.
`timescale 1ns/1ps
`default_nettype none
`include "card_pins_cfg.svh"

module card_bus_handshake_status_pins #(
   parameter int WORD_W = `CFG_WORD_W,
   parameter int ADDR_W = `CFG_ADDR_W,
   parameter int FIFO_DEPTH = `CFG_FIFO_DEPTH,
   parameter int RDY_MARGIN = `CFG_RDY_MARGIN,
   parameter int HALF_CYC = `CFG_HALF_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Mode and burst state from the core
   input wire card_pins_pkg::mode_type mode,
   input wire logic udma_rd,
   input wire logic udma_wr,
   input wire logic init_done,
   // Cycle information from the core
   input wire logic core_busy,
   input wire logic cycle_active,
   input wire logic port16,
   input wire logic word_cycle,
   // Host strobes and data in
   input wire logic we_n,
   input wire logic reg_n,
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic [WORD_W-1:0] host_d,
   input wire logic hstrobe,
   input wire logic host_pause,
   // Card data out during read bursts
   output logic [WORD_W-1:0] dd_o,
   output logic dd_oe,
   // Status pins
   output logic wait_pin,
   output logic status_pin,
   // Register write strobes toward the core
   output logic mem_wr,
   output logic cfg_wr,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [WORD_W-1:0] wr_data,
   // Write burst words toward the core
   output logic core_rx_valid,
   input wire logic core_rx_ready,
   output logic [WORD_W-1:0] core_rx_data,
   // Read burst words from the core
   input wire logic core_tx_valid,
   output logic core_tx_ready,
   input wire logic [WORD_W-1:0] core_tx_data
);

   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int DW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
   localparam logic [LW-1:0] RDY_LIMIT = LW'(FIFO_DEPTH - RDY_MARGIN);
   localparam logic [DW-1:0] DIV_LOAD = DW'(HALF_CYC - 1);
   localparam int EDGE_MAX = 8;

   typedef struct packed {
      logic [DW-1:0] div;
      logic phase;
      logic strobe;
      logic [WORD_W-1:0] dd;
      logic dd_oe;
      logic we_prev;
      logic hs_prev;
      logic mem_wr;
      logic cfg_wr;
      logic [ADDR_W-1:0] wr_addr;
      logic [WORD_W-1:0] wr_data;
      logic pin;
      logic stat;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   card_pins_pkg::pin_fn_type fn;
   logic tick;
   logic we_rise;
   logic hs_edge;
   logic wr_ready;
   logic pop;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [WORD_W-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;
   logic [LW-1:0] fifo_level;

   // Burst buffer; direction follows the active burst
   burst_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // Edge detection on host strobes
   assign we_rise = !s_r.we_prev && we_n;
   assign hs_edge = udma_wr && (hstrobe != s_r.hs_prev);

   // Ready keeps a margin so words already in flight still fit
   assign wr_ready = (fifo_level <= RDY_LIMIT);

   // Divider tick marks each strobe half period; kept out of the next-state process
   assign tick = (s_r.div == '0);

   // Read burst pops one word every second tick; empty buffer or host pause freezes the strobe
   assign pop = udma_rd && !udma_wr && tick && !s_r.phase && fifo_out_valid && !host_pause;

   // Buffer steering: host fills on write bursts, core fills on read bursts
   assign fifo_in_valid = udma_wr ? hs_edge : (udma_rd && core_tx_valid);
   assign fifo_in_data = udma_wr ? host_d : core_tx_data;
   assign fifo_out_ready = udma_wr ? core_rx_ready : pop;
   assign core_tx_ready = udma_rd && !udma_wr && fifo_in_ready;
   assign core_rx_valid = udma_wr && fifo_out_valid;
   assign core_rx_data = fifo_out_data;

   // Pin function select; write burst wins if both flags are seen
   always_comb begin
      if (udma_wr) begin
         fn = card_pins_pkg::FN_DDMARDY;
      end else if (udma_rd) begin
         fn = card_pins_pkg::FN_DSTROBE;
      end else if (mode == card_pins_pkg::MODE_IDE) begin
         fn = card_pins_pkg::FN_IORDY;
      end else begin
         fn = card_pins_pkg::FN_WAIT;
      end
   end

   // Next state of the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.div = tick ? DIV_LOAD : s_r.div - 1'b1;
      s_nxt.we_prev = we_n;
      s_nxt.hs_prev = hstrobe;

      // Read strobe: load a word, then toggle one half period later
      if (!udma_rd || udma_wr) begin
         s_nxt.phase = 1'b0;
         s_nxt.strobe = `CFG_STROBE_RST;
      end else if (pop) begin
         s_nxt.dd = fifo_out_data;
         s_nxt.phase = 1'b1;
      end else if (tick && s_r.phase) begin
         s_nxt.strobe = !s_r.strobe;
         s_nxt.phase = 1'b0;
      end
      // Data lines driven only while a read burst owns them
      s_nxt.dd_oe = udma_rd && !udma_wr;

      // Write strobe decode per mode; True IDE drops it entirely
      s_nxt.mem_wr = 1'b0;
      s_nxt.cfg_wr = 1'b0;
      if (we_rise) begin
         unique case (mode)
            card_pins_pkg::MODE_MEM: begin
               s_nxt.mem_wr = reg_n;
               s_nxt.cfg_wr = !reg_n;
            end
            card_pins_pkg::MODE_IO: begin
               s_nxt.cfg_wr = !reg_n;
            end
            card_pins_pkg::MODE_IDE: begin
               s_nxt.cfg_wr = 1'b0;
            end
            default: begin
               s_nxt.cfg_wr = 1'b0;
            end
         endcase
         if (mode != card_pins_pkg::MODE_IDE) begin
            s_nxt.wr_addr = host_addr;
            s_nxt.wr_data = host_d;
         end
      end

      // Shared wait pin level
      unique case (fn)
         card_pins_pkg::FN_WAIT: s_nxt.pin = !(core_busy && cycle_active);
         card_pins_pkg::FN_IORDY: s_nxt.pin = !core_busy;
         card_pins_pkg::FN_DDMARDY: s_nxt.pin = !wr_ready;
         card_pins_pkg::FN_DSTROBE: s_nxt.pin = s_nxt.strobe;
      endcase

      // Pin 24 meaning depends on the mode
      unique case (mode)
         card_pins_pkg::MODE_MEM: s_nxt.stat = init_done ? 1'b0 : `CFG_STAT_PRE_INIT;
         card_pins_pkg::MODE_IO: s_nxt.stat = !port16;
         card_pins_pkg::MODE_IDE: s_nxt.stat = !word_cycle;
         default: s_nxt.stat = `CFG_STAT_RST;
      endcase
   end

   // Single state register; everything resets to idle levels
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r.div <= '0;
         s_r.phase <= 1'b0;
         s_r.strobe <= `CFG_STROBE_RST;
         s_r.dd <= '0;
         s_r.dd_oe <= 1'b0;
         s_r.we_prev <= `CFG_WE_IDLE;
         s_r.hs_prev <= 1'b0;
         s_r.mem_wr <= 1'b0;
         s_r.cfg_wr <= 1'b0;
         s_r.wr_addr <= '0;
         s_r.wr_data <= '0;
         s_r.pin <= `CFG_PIN_RST;
         s_r.stat <= `CFG_STAT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign dd_o = s_r.dd;
   assign dd_oe = s_r.dd_oe;
   assign wait_pin = s_r.pin;
   assign status_pin = s_r.stat;
   assign mem_wr = s_r.mem_wr;
   assign cfg_wr = s_r.cfg_wr;
   assign wr_addr = s_r.wr_addr;
   assign wr_data = s_r.wr_data;

   // Checks on the pins this block drives
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence load_seq;
      udma_rd && !udma_wr && pop;
   endsequence

   sequence idle_seq;
      udma_rd && !udma_wr && !s_r.phase && !fifo_out_valid ##1 udma_rd && !udma_wr;
   endsequence

   // Host strobe low on one edge, high on the next
   sequence we_release_seq;
      !we_n ##1 we_n;
   endsequence

   chk_wait_stretch: assert property (
      (!udma_rd && !udma_wr && mode != card_pins_pkg::MODE_IDE && core_busy && cycle_active)
      |=> !wait_pin)
      else $error("wait pin not low while core busy in cycle");

   chk_iordy_follow: assert property (
      (!udma_rd && !udma_wr && mode == card_pins_pkg::MODE_IDE)
      |=> (wait_pin != $past(core_busy)))
      else $error("ready pin does not follow core busy");

   chk_ddmardy_ready: assert property (
      (udma_wr && fifo_level <= RDY_LIMIT) |=> !wait_pin)
      else $error("write ready not asserted with room in buffer");

   chk_ddmardy_pause: assert property (
      (udma_wr && fifo_level > RDY_LIMIT) |=> wait_pin)
      else $error("write ready not dropped with buffer nearly full");

   chk_strobe_word: assert property (
      load_seq |=> (s_r.dd == $past(fifo_out_data)) ##[0:EDGE_MAX] $changed(s_r.strobe))
      else $error("loaded word not followed by a strobe edge");

   chk_strobe_cause: assert property (
      ($changed(s_r.strobe) && udma_rd && $past(udma_rd) && !$past(udma_wr))
      |-> $past(s_r.phase))
      else $error("strobe edge without a loaded word");

   chk_strobe_freeze: assert property (
      idle_seq |-> $stable(s_r.strobe))
      else $error("strobe moved while buffer empty");

   chk_mem_we: assert property (
      (mode == card_pins_pkg::MODE_MEM && we_rise) |=> (mem_wr == $past(reg_n)) && (cfg_wr != mem_wr))
      else $error("memory mode write strobe decoded wrong");

   chk_io_we: assert property (
      (mode == card_pins_pkg::MODE_IO) |=> !mem_wr)
      else $error("memory write raised in io mode");

   chk_ide_we: assert property (
      (mode == card_pins_pkg::MODE_IDE) |=> !(mem_wr || cfg_wr))
      else $error("write strobe honoured in ide mode");

   chk_wp_low: assert property (
      (mode == card_pins_pkg::MODE_MEM && init_done) |=> !status_pin)
      else $error("write protect not low after init");

   chk_iois16_low: assert property (
      (mode == card_pins_pkg::MODE_IO) |=> (status_pin == !$past(port16)))
      else $error("16-bit port indication wrong");

   chk_iocs16_low: assert property (
      (mode == card_pins_pkg::MODE_IDE) |=> (status_pin == !$past(word_cycle)))
      else $error("word cycle indication wrong");

   // Pin function, burst ownership, write strobe decode and write protect
   chk_strobe_on_pin: assert property (
      (udma_rd && !udma_wr) |=> (wait_pin == s_r.strobe))
      else $error("read strobe not carried on the wait pin");

   chk_write_wins: assert property (
      (udma_rd && udma_wr) |=> (!dd_oe && (wait_pin == !$past(wr_ready))))
      else $error("read burst not overridden by write burst");

   chk_data_drive: assert property (
      (udma_rd && !udma_wr) |=> dd_oe)
      else $error("data lines not driven during read burst");

   chk_pause_hold: assert property (
      (udma_rd && !udma_wr && host_pause) |=> $stable(dd_o))
      else $error("new word loaded while host paused");

   chk_io_cfg_we: assert property (
      (mode == card_pins_pkg::MODE_IO && we_rise) |=> (cfg_wr == !$past(reg_n)))
      else $error("io mode config write decoded wrong");

   chk_we_edge: assert property (
      we_release_seq ##0 (mode == card_pins_pkg::MODE_MEM) |=> (mem_wr || cfg_wr))
      else $error("memory mode write strobe release not answered");

   chk_wp_pre_init: assert property (
      (mode == card_pins_pkg::MODE_MEM && !init_done) |=> status_pin)
      else $error("write protect low before init");

endmodule

`default_nettype wire

// [bench/host_model.sv]
// Behavioural host controller facing the card's handshake pins.
// Assumes it shares mclk with the card and moves 1 ns after an edge.
`timescale 1ns/1ps
`default_nettype none
`include "card_pins_cfg.svh"

module host_model (
   // Clock
   input wire logic mclk,
   // Card pins watched
   input wire logic wait_pin,
   input wire logic dd_oe,
   input wire logic [`CFG_WORD_W-1:0] dd_o,
   // Host strobes and data
   output logic we_n,
   output logic reg_n,
   output logic [`CFG_ADDR_W-1:0] host_addr,
   output logic [`CFG_WORD_W-1:0] host_d,
   output logic hstrobe
);
   logic [`CFG_WORD_W-1:0] rd_q[$];
   logic last_lvl;
   logic oe_d;

   // Idle bus levels
   initial begin
      we_n = 1'h1;
      reg_n = 1'h1;
      host_addr = '0;
      host_d = '0;
      hstrobe = 1'h0;
      last_lvl = 1'h0;
      oe_d = 1'h0;
   end

   // Latch a read word on every strobe change, either direction
   always @(posedge mclk) begin
      if (dd_oe && oe_d && wait_pin !== last_lvl) begin
         rd_q.push_back(dd_o);
      end
      last_lvl <= wait_pin;
      oe_d <= dd_oe;
   end

   // One register write; address and data stand on the rising strobe
   task automatic reg_write(input logic reg_sel, input logic [`CFG_ADDR_W-1:0] addr,
                            input logic [`CFG_WORD_W-1:0] data);
      we_n = 1'h0;
      @(posedge mclk);
      #1;
      we_n = 1'h1;
      reg_n = reg_sel;
      host_addr = addr;
      host_d = data;
      @(posedge mclk);
      #1;
      host_d = ~data; // Released data shows no stale value
   endtask

   // One write-burst word, only while the card shows write-ready
   task automatic burst_word(input logic [`CFG_WORD_W-1:0] data, output logic sent);
      sent = (wait_pin === 1'h0);
      if (sent) begin
         host_d = data;
         hstrobe = ~hstrobe;
      end
      @(posedge mclk);
      #1;
   endtask
endmodule
`default_nettype wire

// [bench/card_bus_handshake_status_pins_tb.sv]
// Self-checking bench for the card handshake and status pins.
// Assumes the design's defaults: 8-word buffer, margin 2, half period 2.
`timescale 1ns/1ps
`default_nettype none

module card_bus_handshake_status_pins_tb;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   card_pins_pkg::mode_type mode = card_pins_pkg::MODE_MEM;
   logic udma_rd = 1'h0, udma_wr = 1'h0, init_done = 1'h0, core_busy = 1'h0;
   logic cycle_active = 1'h1, port16 = 1'h0, word_cycle = 1'h0, host_pause = 1'h0;
   logic we_n, reg_n, hstrobe, core_rx_ready = 1'h0, core_tx_valid = 1'h0;
   logic [10:0] host_addr, wr_addr;
   logic [15:0] host_d, dd_o, wr_data, core_rx_data, core_tx_data = 16'h0;
   logic dd_oe, wait_pin, status_pin, mem_wr, cfg_wr, core_rx_valid, core_tx_ready;
   int n_errors = 0;
   int n_tests = 0;

   card_bus_handshake_status_pins i_card_bus_handshake_status_pins (.mclk(mclk), .rst(rst),
      .mode(mode), .udma_rd(udma_rd), .udma_wr(udma_wr), .init_done(init_done),
      .core_busy(core_busy), .cycle_active(cycle_active), .port16(port16),
      .word_cycle(word_cycle), .we_n(we_n), .reg_n(reg_n), .host_addr(host_addr),
      .host_d(host_d), .hstrobe(hstrobe), .host_pause(host_pause), .dd_o(dd_o),
      .dd_oe(dd_oe), .wait_pin(wait_pin), .status_pin(status_pin), .mem_wr(mem_wr),
      .cfg_wr(cfg_wr), .wr_addr(wr_addr), .wr_data(wr_data),
      .core_rx_valid(core_rx_valid), .core_rx_ready(core_rx_ready),
      .core_rx_data(core_rx_data), .core_tx_valid(core_tx_valid),
      .core_tx_ready(core_tx_ready), .core_tx_data(core_tx_data));

   host_model host (.mclk(mclk), .wait_pin(wait_pin), .dd_oe(dd_oe), .dd_o(dd_o),
      .we_n(we_n), .reg_n(reg_n), .host_addr(host_addr), .host_d(host_d),
      .hstrobe(hstrobe));

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   // Compare and count; case inequality, so an unknown matches only the same unknown
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Pin levels for one mode setting, settled two edges later
   task automatic stat_case(input card_pins_pkg::mode_type m, input logic busy,
                            input logic p16, input logic word, input logic init,
                            input logic exp_wait, input logic exp_stat);
      mode = m;
      core_busy = busy;
      port16 = p16;
      word_cycle = word;
      init_done = init;
      step(2);
      check(wait_pin, exp_wait);
      check(status_pin, exp_stat);
   endtask

   // One host write; count strobe pulses over four cycles
   task automatic wr_case(input card_pins_pkg::mode_type m, input logic rsel,
                          input logic [10:0] a, input logic exp_m, input logic exp_c);
      int nm;
      int nc;
      nm = 0;
      nc = 0;
      mode = m;
      host.reg_write(rsel, a, {5'h0, a});
      repeat (4) begin
         nm += (mem_wr === 1'h1);
         nc += (cfg_wr === 1'h1);
         step(1);
      end
      check(nm, exp_m);
      check(nc, exp_c);
   endtask

   // Write burst: host stops on write-ready, core drains in order
   task automatic write_burst();
      logic sent;
      mode = card_pins_pkg::MODE_MEM;
      udma_wr = 1'h1;
      udma_rd = 1'h1;
      step(2);
      check(core_tx_ready, 1'h0);
      check(dd_oe, 1'h0);
      udma_rd = 1'h0;
      for (int k = 1; k <= 9; k++) begin
         host.burst_word(16'ha000 + k, sent);
         check(sent, k <= 7);
         step(2);
         check(wait_pin, k >= 7);
      end
      core_rx_ready = 1'h1;
      for (int k = 1; k <= 7; k++) begin
         check(core_rx_valid, 1'h1);
         check(core_rx_data, 16'ha000 + k);
         step(1);
      end
      core_rx_ready = 1'h0;
      check(core_rx_valid, 1'h0);
      step(2);
      check(wait_pin, 1'h0);
      udma_wr = 1'h0;
   endtask

   // Read burst: fill buffer while paused, then stream on strobe edges
   task automatic read_burst();
      logic lvl;
      mode = card_pins_pkg::MODE_IDE;
      udma_rd = 1'h1;
      host_pause = 1'h1;
      core_tx_valid = 1'h1;
      for (int i = 0; i <= 8; i++) begin
         core_tx_data = 16'hc000 + i;
         @(negedge mclk);
         check(core_tx_ready, i < 8);
         step(1);
      end
      core_tx_valid = 1'h0;
      step(2);
      lvl = wait_pin;
      host.rd_q.delete();
      step(8);
      check(wait_pin, lvl);
      check(dd_oe, 1'h1);
      host_pause = 1'h0;
      step(60);
      check(host.rd_q.size(), 8);
      for (int i = 0; i < 8; i++) begin
         check(host.rd_q[i], 16'hc000 + i);
      end
      udma_rd = 1'h0;
      step(2);
      check(dd_oe, 1'h0);
   endtask

   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      step(3);
      rst = 1'h0;
      step(1);
      stat_case(card_pins_pkg::MODE_MEM, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      stat_case(card_pins_pkg::MODE_MEM, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
      cycle_active = 1'h0;
      stat_case(card_pins_pkg::MODE_MEM, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
      cycle_active = 1'h1;
      stat_case(card_pins_pkg::MODE_IO, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
      stat_case(card_pins_pkg::MODE_IO, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
      stat_case(card_pins_pkg::MODE_IDE, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      stat_case(card_pins_pkg::MODE_IDE, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
      wr_case(card_pins_pkg::MODE_MEM, 1'h1, 11'h011, 1'h1, 1'h0);
      check(wr_data, 16'h0011);
      wr_case(card_pins_pkg::MODE_MEM, 1'h0, 11'h012, 1'h0, 1'h1);
      wr_case(card_pins_pkg::MODE_IO, 1'h0, 11'h013, 1'h0, 1'h1);
      wr_case(card_pins_pkg::MODE_IO, 1'h1, 11'h014, 1'h0, 1'h0);
      wr_case(card_pins_pkg::MODE_IDE, 1'h0, 11'h015, 1'h0, 1'h0);
      check(wr_addr, 11'h014);
      write_burst();
      read_burst();
      report_and_stop();
   end

   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      #50000;
      n_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
